// *** hdl/ecsp_pkg.sv ***
package ecsp_pkg;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          CNT_W        = 16;
	// register byte offsets
	localparam logic [7:0]  OFF_CFG      = 8'h00;
	localparam logic [7:0]  OFF_PKT      = 8'h04;
	localparam logic [7:0]  OFF_SERVICE_INTERVAL_WINDOW     = 8'h08;
	localparam logic [7:0]  OFF_CMD      = 8'h0c;
	localparam logic [7:0]  OFF_SID      = 8'h10;
	localparam logic [7:0]  OFF_STRM_LO  = 8'h14;
	localparam logic [7:0]  OFF_STRM_HI  = 8'h18;
	localparam logic [7:0]  OFF_STRM_LEN = 8'h1c;
	localparam logic [7:0]  OFF_STATUS   = 8'h20;
	localparam logic [7:0]  OFF_CAPS     = 8'h24;
	// endpoint configuration word fields
	localparam int          SPEED_LSB    = 0;
	localparam int          KIND_LSB     = 3;
	localparam int          DIR_BIT      = 5;
	localparam int          MULT_LSB     = 6;
	localparam int          BURST_LSB    = 8;
	localparam int          INTV_LSB     = 16;
	localparam int          ERROR_RETRY_COUNT_LSB     = 24;
	localparam int          STATE_LSB    = 28;
	localparam logic [31:0] CFG_KEEP     = 32'h0300_003f;
	localparam int          MPS_W        = 11;
	localparam int          SERVICE_INTERVAL_WINDOW_W       = 24;
	localparam int          SID_W        = 16;
	localparam int          PTR_LSB      = 4;
	localparam int          KIND_S_LSB   = 1;
	localparam int          CMD_RST_BIT  = 0;
	localparam logic [7:0]  INTV_MAX     = 8'h0f;
	localparam logic [23:0] SERVICE_INTERVAL_WINDOW_SMALL   = 24'h00c000;
	localparam logic [15:0] SID_RSVD     = 16'h0000;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
	// microframe timing
	localparam int          UFRAME_NS    = 125000;
	localparam int          CLK_NS       = 5;
	localparam int          UFRAME_CYC   = UFRAME_NS / CLK_NS;

	typedef enum logic [2:0] {
		SPD_FS  = 3'b000,
		SPD_LS  = 3'b001,
		SPD_HS  = 3'b010,
		SPD_SS  = 3'b011,
		SPD_SSP = 3'b100
	} ecsp_speed_type;

	typedef enum logic [1:0] {
		EPK_CTRL = 2'b00,
		EPK_ISOC = 2'b01,
		EPK_BULK = 2'b10,
		EPK_INTR = 2'b11
	} ecsp_kind_type;

	typedef enum logic [2:0] {
		EPS_DISABLED = 3'b000,
		EPS_RUNNING  = 3'b001,
		EPS_HALTED   = 3'b010,
		EPS_STOPPED  = 3'b011
	} ecsp_state_type;
endpackage : ecsp_pkg

// *** hdl/ecsp_top.sv ***
`timescale 1ns/10ps
// Functional notes
// - transactions per opportunity at most (burst+1)*(mult+1)
// - packet bytes capped at max packet; nonzero burst means high bandwidth
// - max packet size is a plain byte count from bits 10:0
// - polling period is 125 us times two to the interval, 0 to 15
// - high-speed bulk/control OUT: interval is NAK rate, zero never NAKs
// - interval ignored for superspeed bulk and control endpoints
// - device reset keeps packet, type, retries, pointer, length; runs
// - service window payload reserves periodic bus time
// - without large payload capability payload limit is 48K bytes
// - with large payload capability payload limit is 16MB-1 bytes
// - stream identifier zero never references a ring or array
// - stream context output fields show the values in use
// - stream entry: cycle bit, kind, pointer lo, pointer hi, length
// - cycle bit is the consumer cycle state of the dequeued entry
module ecsp_top #(
	parameter int P_UFRAME_CYCLES = ecsp_pkg::UFRAME_CYC
) (
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_reset_n,
	input  wire logic                         i_clk_en,
	input  wire logic [ecsp_pkg::ADDR_W-1:0]  i_axi_awaddr,
	input  wire logic                         i_axi_awvalid,
	output logic                              o_axi_awready,
	input  wire logic [ecsp_pkg::DATA_W-1:0]  i_axi_wdata,
	input  wire logic [3:0]                   i_axi_wstrb,
	input  wire logic                         i_axi_wvalid,
	output logic                              o_axi_wready,
	output logic [1:0]                        o_axi_bresp,
	output logic                              o_axi_bvalid,
	input  wire logic                         i_axi_bready,
	input  wire logic [ecsp_pkg::ADDR_W-1:0]  i_axi_araddr,
	input  wire logic                         i_axi_arvalid,
	output logic                              o_axi_arready,
	output logic [ecsp_pkg::DATA_W-1:0]       o_axi_rdata,
	output logic [1:0]                        o_axi_rresp,
	output logic                              o_axi_rvalid,
	input  wire logic                         i_axi_rready,
	input  wire logic                         i_large_payload_capable,
	input  wire logic                         i_nak_used,
	input  wire logic                         i_wb_valid,
	input  wire logic [63:4]                  i_wb_ptr,
	input  wire logic                         i_wb_cycle,
	input  wire logic [ecsp_pkg::SERVICE_INTERVAL_WINDOW_W-1:0]  i_wb_len,
	output logic [10:0]                       o_txn_budget,
	output logic [8:0]                        o_pkt_per_txn,
	output logic                              o_high_bw,
	output logic [ecsp_pkg::MPS_W-1:0]        o_max_pkt_bytes,
	output logic                              o_poll_tick,
	output logic                              o_nak_allowed,
	output logic [ecsp_pkg::SERVICE_INTERVAL_WINDOW_W-1:0]       o_reserve_bytes,
	output logic                              o_payload_ok,
	output logic [63:0]                       o_ring_addr,
	output logic                              o_ring_valid,
	output logic                              o_dequeue_cycle_bit,
	output logic [2:0]                        o_ep_state
);
	import ecsp_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction : merge

	logic        awrdy_r, wrdy_r, bvalid_r, ardy_r, rvalid_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0]  wstrb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] cfg_r, pkt_r, slo_r, shi_r;
	logic [23:0] service_interval_window_r, slen_r;
	logic [15:0] sid_r, cyc_cnt_r, uf_cnt_r;
	logic [10:0] budget_r;
	logic [8:0]  ppt_r;
	logic        high_bw_r, tick_r, nak_ok_r, pay_ok_r, ring_ok_r;
	logic [23:0] reserve_r;
	logic [63:0] ring_addr_r;

	// write channel: address and data taken in either order, then applied
	wire        wr_fire  = !awrdy_r && !wrdy_r && !bvalid_r;
	wire [7:0]  wa       = {awaddr_r[7:2], 2'b00};
	wire        hit_cfg  = wr_fire && wa == OFF_CFG;
	wire        hit_pkt  = wr_fire && wa == OFF_PKT;
	wire        hit_service_interval_window = wr_fire && wa == OFF_SERVICE_INTERVAL_WINDOW;
	wire        hit_cmd  = wr_fire && wa == OFF_CMD;
	wire        hit_sid  = wr_fire && wa == OFF_SID;
	wire        hit_slo  = wr_fire && wa == OFF_STRM_LO;
	wire        hit_shi  = wr_fire && wa == OFF_STRM_HI;
	wire        hit_slen = wr_fire && wa == OFF_STRM_LEN;
	wire        wr_map   = hit_cfg | hit_pkt | hit_service_interval_window | hit_cmd | hit_sid
		| hit_slo | hit_shi | hit_slen | (wa == OFF_STATUS)
		| (wa == OFF_CAPS);
	wire        dev_rst  = hit_cmd && wstrb_r[0] && wdata_r[CMD_RST_BIT];
	wire [31:0] wmerge_cfg = merge(cfg_r, wdata_r, wstrb_r);

	// device reset keeps packet size, type and retries, and sets the running state
	wire [31:0] cfg_nxt = dev_rst ? ((cfg_r & CFG_KEEP)
			| (32'(EPS_RUNNING) << STATE_LSB)) :
		hit_cfg ? wmerge_cfg : cfg_r;
	wire [31:0] pkt_nxt = hit_pkt ? merge(pkt_r, wdata_r, wstrb_r) : pkt_r;
	wire [31:0] service_interval_window_w  = merge({8'h00, service_interval_window_r}, wdata_r, wstrb_r);
	wire [23:0] service_interval_window_nxt = dev_rst ? RST_WORD[23:0] :
		hit_service_interval_window ? service_interval_window_w[23:0] : service_interval_window_r;
	wire [31:0] sid_w   = merge({16'h0000, sid_r}, wdata_r, wstrb_r);
	wire [15:0] sid_nxt = hit_sid ? sid_w[15:0] : sid_r;
	// the scheduler's write-back outranks software: it is the value in use
	wire [31:0] slo_nxt = i_wb_valid ?
		{i_wb_ptr[31:PTR_LSB], slo_r[3:1], i_wb_cycle} :
		hit_slo ? merge(slo_r, wdata_r, wstrb_r) : slo_r;
	wire [31:0] shi_nxt = i_wb_valid ? i_wb_ptr[63:32] :
		hit_shi ? merge(shi_r, wdata_r, wstrb_r) : shi_r;
	wire [31:0] slen_w  = merge({8'h00, slen_r}, wdata_r, wstrb_r);
	wire [23:0] slen_nxt = i_wb_valid ? i_wb_len :
		hit_slen ? slen_w[23:0] : slen_r;

	// endpoint field decode
	wire [2:0]  speed    = cfg_r[SPEED_LSB +: 3];
	wire [1:0]  kind     = cfg_r[KIND_LSB +: 2];
	wire        dir_in   = cfg_r[DIR_BIT];
	wire [1:0]  mult     = cfg_r[MULT_LSB +: 2];
	wire [7:0]  burst    = cfg_r[BURST_LSB +: 8];
	wire [7:0]  intv     = cfg_r[INTV_LSB +: 8];
	wire        is_ss    = speed == SPD_SS || speed == SPD_SSP;
	wire        is_hs    = speed == SPD_HS;
	wire        async_k  = kind == EPK_BULK || kind == EPK_CTRL;
	wire        periodic = !async_k;
	wire        nak_mode = is_hs && (kind == EPK_BULK
		|| (kind == EPK_CTRL && !dir_in));
	wire        intv_use = !(is_ss && async_k);

	wire [8:0]  ppt_nxt    = {1'b0, burst} + 9'h001;
	wire [2:0]  mlt_nxt    = {1'b0, mult} + 3'h1;
	wire [10:0] budget_nxt = 11'(ppt_nxt) * 11'(mlt_nxt);
	// intervals beyond the largest exponent saturate
	wire [3:0]  intv_exp   = (intv > INTV_MAX) ? INTV_MAX[3:0] : intv[3:0];
	wire [15:0] poll_last  = (16'h0001 << intv_exp) - 16'h0001;
	wire [15:0] nak_last   = {8'h00, intv} - 16'h0001;
	wire [15:0] win_last   = nak_mode ? nak_last : poll_last;
	wire        uf_tick    = cyc_cnt_r == 16'(P_UFRAME_CYCLES - 1);
	wire        win_end    = uf_tick && uf_cnt_r >= win_last;
	wire        tick_nxt   = win_end && periodic && intv_use;
	wire        nak_set    = win_end && nak_mode && intv != 8'h00;
	wire        nak_nxt    = nak_set ||
		(nak_ok_r && !i_nak_used && nak_mode && intv != 8'h00);
	wire        pay_ok_nxt = i_large_payload_capable ||
		service_interval_window_r <= SERVICE_INTERVAL_WINDOW_SMALL;
	wire [23:0] rsv_nxt    = (periodic && pay_ok_nxt) ? service_interval_window_r :
		RST_WORD[23:0];
	wire        ring_nxt   = sid_r != SID_RSVD;
	wire [63:0] addr_nxt   = {shi_r, slo_r[31:PTR_LSB], 4'h0};

	// read decode
	wire [7:0]  ra       = {i_axi_araddr[7:2], 2'b00};
	wire [31:0] status_w = {16'h0000, ring_ok_r, nak_mode, intv_use,
		pay_ok_r, high_bw_r, budget_r};
	wire        rd_map   = ra == OFF_CFG || ra == OFF_PKT || ra == OFF_SERVICE_INTERVAL_WINDOW
		|| ra == OFF_CMD || ra == OFF_SID || ra == OFF_STRM_LO
		|| ra == OFF_STRM_HI || ra == OFF_STRM_LEN || ra == OFF_STATUS
		|| ra == OFF_CAPS;
	wire [31:0] rd_mux =
		(ra == OFF_CFG)      ? cfg_r :
		(ra == OFF_PKT)      ? pkt_r :
		(ra == OFF_SERVICE_INTERVAL_WINDOW)     ? {8'h00, service_interval_window_r} :
		(ra == OFF_SID)      ? {16'h0000, sid_r} :
		(ra == OFF_STRM_LO)  ? slo_r :
		(ra == OFF_STRM_HI)  ? shi_r :
		(ra == OFF_STRM_LEN) ? {8'h00, slen_r} :
		(ra == OFF_STATUS)   ? status_w :
		(ra == OFF_CAPS)     ? {31'h0, i_large_payload_capable} : RST_WORD;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			awrdy_r  <= 1'b1;
			wrdy_r   <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r  <= RST_WORD;
			wstrb_r  <= 4'h0;
		end else if (i_clk_en) begin
			if (awrdy_r && i_axi_awvalid) begin
				awrdy_r  <= 1'b0;
				awaddr_r <= i_axi_awaddr;
			end
			if (wrdy_r && i_axi_wvalid) begin
				wrdy_r  <= 1'b0;
				wdata_r <= i_axi_wdata;
				wstrb_r <= i_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && i_axi_bready) begin
				bvalid_r <= 1'b0;
				awrdy_r  <= 1'b1;
				wrdy_r   <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ardy_r   <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r  <= RST_WORD;
			rresp_r  <= RESP_OKAY;
		end else if (i_clk_en) begin
			if (ardy_r && i_axi_arvalid) begin
				ardy_r   <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r  <= rd_mux;
				rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && i_axi_rready) begin
				rvalid_r <= 1'b0;
				ardy_r   <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_r  <= RST_WORD;
			pkt_r  <= RST_WORD;
			service_interval_window_r <= RST_WORD[23:0];
			sid_r  <= SID_RSVD;
			slo_r  <= RST_WORD;
			shi_r  <= RST_WORD;
			slen_r <= RST_WORD[23:0];
		end else if (i_clk_en) begin
			cfg_r  <= cfg_nxt;
			pkt_r  <= pkt_nxt;
			service_interval_window_r <= service_interval_window_nxt;
			sid_r  <= sid_nxt;
			slo_r  <= slo_nxt;
			shi_r  <= shi_nxt;
			slen_r <= slen_nxt;
		end
	end

	// microframe and window counters
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cyc_cnt_r <= 16'h0000;
			uf_cnt_r  <= 16'h0000;
		end else if (i_clk_en) begin
			cyc_cnt_r <= uf_tick ? 16'h0000 : cyc_cnt_r + 16'h0001;
			if (uf_tick)
				uf_cnt_r <= win_end ? 16'h0000 : uf_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			budget_r    <= 11'h000;
			ppt_r       <= 9'h000;
			high_bw_r   <= 1'b0;
			tick_r      <= 1'b0;
			nak_ok_r    <= 1'b0;
			pay_ok_r    <= 1'b0;
			reserve_r   <= 24'h000000;
			ring_ok_r   <= 1'b0;
			ring_addr_r <= 64'h0;
		end else if (i_clk_en) begin
			budget_r    <= budget_nxt;
			ppt_r       <= ppt_nxt;
			high_bw_r   <= burst != 8'h00;
			tick_r      <= tick_nxt;
			nak_ok_r    <= nak_nxt;
			pay_ok_r    <= pay_ok_nxt;
			reserve_r   <= rsv_nxt;
			ring_ok_r   <= ring_nxt;
			ring_addr_r <= addr_nxt;
		end
	end

	assign o_axi_awready       = awrdy_r;
	assign o_axi_wready        = wrdy_r;
	assign o_axi_bvalid        = bvalid_r;
	assign o_axi_bresp         = bresp_r;
	assign o_axi_arready       = ardy_r;
	assign o_axi_rvalid        = rvalid_r;
	assign o_axi_rdata         = rdata_r;
	assign o_axi_rresp         = rresp_r;
	assign o_txn_budget        = budget_r;
	assign o_pkt_per_txn       = ppt_r;
	assign o_high_bw           = high_bw_r;
	assign o_max_pkt_bytes     = pkt_r[MPS_W-1:0];
	assign o_poll_tick         = tick_r;
	assign o_nak_allowed       = nak_ok_r;
	assign o_reserve_bytes     = reserve_r;
	assign o_payload_ok        = pay_ok_r;
	assign o_ring_addr         = ring_addr_r;
	assign o_ring_valid        = ring_ok_r;
	assign o_dequeue_cycle_bit = slo_r[0];
	assign o_ep_state          = cfg_r[STATE_LSB +: 3];

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	budget_product_a: assert property (i_clk_en |=>
		o_txn_budget == 11'({1'b0, $past(burst)} + 9'h001)
		* 11'({1'b0, $past(mult)} + 3'h1))
		else $error("transaction budget mismatch");
	high_bw_flag_a: assert property (i_clk_en |=>
		o_high_bw == ($past(burst) != 8'h00)
		&& o_pkt_per_txn == {1'b0, $past(burst)} + 9'h001)
		else $error("high bandwidth flag wrong");
	poll_window_a: assert property (o_poll_tick |->
		$past(uf_cnt_r) >= $past(poll_last) && $past(periodic))
		else $error("poll tick outside window end");
	nak_zero_a: assert property (i_clk_en && intv == 8'h00
		|=> !o_nak_allowed)
		else $error("nak allowed with zero rate");
	ss_intv_ignored_a: assert property (i_clk_en && is_ss
		&& async_k |=> !o_poll_tick && !o_nak_allowed)
		else $error("interval used on superspeed async");
	dev_reset_a: assert property (i_clk_en && dev_rst
		|=> o_ep_state == EPS_RUNNING && burst == 8'h00 && mult == 2'b00
		&& intv == 8'h00 && service_interval_window_r == 24'h0 && $stable(pkt_r))
		else $error("device reset fields wrong");
	reserve_bytes_a: assert property (i_clk_en && !periodic
		|=> o_reserve_bytes == 24'h0)
		else $error("async endpoint reserved time");
	payload_limit_a: assert property (i_clk_en
		&& !i_large_payload_capable && service_interval_window_r > SERVICE_INTERVAL_WINDOW_SMALL
		|=> !o_payload_ok)
		else $error("payload above small limit accepted");
	stream_zero_a: assert property (i_clk_en && sid_r == SID_RSVD
		|=> !o_ring_valid)
		else $error("reserved stream used as ring");
	writeback_a: assert property (i_clk_en && i_wb_valid
		|=> slen_r == $past(i_wb_len)
		&& o_dequeue_cycle_bit == $past(i_wb_cycle))
		else $error("stream write-back lost");
	addr_align_a: assert property (o_ring_addr[3:0] == 4'h0)
		else $error("ring address misaligned");

	cover_dev_reset_c: cover property (i_clk_en && dev_rst);
	cover_poll_tick_c: cover property (o_poll_tick);
	cover_nak_c:       cover property (o_nak_allowed ##1 !o_nak_allowed);
	cover_slverr_c:    cover property (o_axi_bvalid
		&& o_axi_bresp == RESP_SLVERR);
endmodule : ecsp_top

// *** verification/ecsp_sw_model.sv ***
`timescale 1ns/10ps
// software side: programs context fields and speaks the register bus
module ecsp_sw_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_awready,
	input  wire logic        i_wready,
	input  wire logic        i_bvalid,
	input  wire logic        i_arready,
	input  wire logic        i_rvalid,
	output logic [7:0]       o_awaddr,
	output logic             o_awvalid,
	output logic [31:0]      o_wdata,
	output logic             o_wvalid,
	output logic             o_bready,
	output logic [7:0]       o_araddr,
	output logic             o_arvalid,
	output logic             o_rready
);
	import ecsp_pkg::*;
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
	end
	function automatic logic [7:0] burst_for(input ecsp_speed_type sp,
		input ecsp_kind_type k, input logic [15:0] desc, input logic [7:0] comp);
		if (sp == SPD_FS || sp == SPD_LS) return 8'h0;
		if (sp == SPD_HS && (k == EPK_CTRL || k == EPK_BULK)) return 8'h0;
		if (sp == SPD_HS) return {6'h0, desc[12:11]};
		return comp;
	endfunction : burst_for
	function automatic logic [7:0] intv_for(input ecsp_speed_type sp,
		input ecsp_kind_type k, input logic [7:0] bi);
		int v;
		v = 3;
		if ((sp == SPD_FS || sp == SPD_LS) && k == EPK_INTR) begin
			while (v < 10 && (1 << (v + 1)) <= bi * 8) v++;
			return 8'(v);
		end
		if (sp == SPD_FS) return 8'(bi + 2);
		return 8'(bi - 1);
	endfunction : intv_for
	task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		o_awaddr  <= a;
		o_awvalid <= 1'b1;
		o_wdata   <= d;
		o_wvalid  <= 1'b1;
		o_bready  <= 1'b1;
		do begin
			@(posedge i_ref_clk);
			if (o_awvalid && i_awready) o_awvalid <= 1'b0;
			if (o_wvalid && i_wready) o_wvalid <= 1'b0;
		end while (!(i_bvalid && o_bready));
		o_bready <= 1'b0;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a);
		@(posedge i_ref_clk);
		o_araddr  <= a;
		o_arvalid <= 1'b1;
		o_rready  <= 1'b1;
		do begin
			@(posedge i_ref_clk);
			if (o_arvalid && i_arready) o_arvalid <= 1'b0;
		end while (!(i_rvalid && o_rready));
		o_rready <= 1'b0;
	endtask : read_reg
endmodule : ecsp_sw_model

// *** verification/test_endpoint_context_scheduling_params.sv ***
`timescale 1ns/10ps
module test_endpoint_context_scheduling_params;
	import ecsp_pkg::*;
	typedef struct {string nm; logic [33:0] v; logic [33:0] m;} ecsp_note_type;
	logic        i_ref_clk = 1'b0, i_reset_n = 1'b0, i_clk_en = 1'b1;
	logic [7:0]  i_axi_awaddr, i_axi_araddr;
	logic [31:0] i_axi_wdata;
	logic [3:0]  i_axi_wstrb = 4'hf;
	logic        i_axi_awvalid, i_axi_wvalid, i_axi_bready;
	logic        i_axi_arvalid, i_axi_rready;
	logic        i_large_payload_capable = 1'b0, i_nak_used = 1'b0;
	logic        i_wb_valid = 1'b0, i_wb_cycle = 1'b0;
	logic [63:4] i_wb_ptr = '0;
	logic [23:0] i_wb_len = '0;
	logic        o_axi_awready, o_axi_wready, o_axi_bvalid;
	logic        o_axi_arready, o_axi_rvalid;
	logic [1:0]  o_axi_bresp, o_axi_rresp;
	logic [31:0] o_axi_rdata;
	logic [10:0] o_txn_budget, o_max_pkt_bytes;
	logic [8:0]  o_pkt_per_txn;
	logic        o_high_bw, o_poll_tick, o_nak_allowed, o_payload_ok;
	logic        o_ring_valid, o_dequeue_cycle_bit;
	logic [23:0] o_reserve_bytes;
	logic [63:0] o_ring_addr, wp;
	logic [2:0]  o_ep_state;
	logic [7:0]  b, iv;
	logic [1:0]  m;
	logic [15:0] desc;
	logic [31:0] c, lo, hi, val;
	logic        ok;
	int          mismatches = 0, check_count = 0, seed = 32'h94080596, n;
	ecsp_speed_type sp;
	ecsp_kind_type  k;
	ecsp_note_type  nt, rq[$];
	logic [1:0]     bq[$];
	ecsp_speed_type psp[3] = '{SPD_HS, SPD_FS, SPD_FS};
	ecsp_kind_type  pk[3] = '{EPK_INTR, EPK_ISOC, EPK_INTR};
	logic [7:0]     pbi[3] = '{8'h1, 8'h1, 8'h4};

	always #2.5 i_ref_clk = ~i_ref_clk;

	ecsp_top #(.P_UFRAME_CYCLES(8)) u_dut (.i_ref_clk, .i_reset_n, .i_clk_en,
		.i_axi_awaddr, .i_axi_awvalid, .o_axi_awready, .i_axi_wdata,
		.i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp,
		.o_axi_bvalid, .i_axi_bready, .i_axi_araddr, .i_axi_arvalid,
		.o_axi_arready, .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid,
		.i_axi_rready, .i_large_payload_capable, .i_nak_used, .i_wb_valid,
		.i_wb_ptr, .i_wb_cycle, .i_wb_len, .o_txn_budget, .o_pkt_per_txn,
		.o_high_bw, .o_max_pkt_bytes, .o_poll_tick, .o_nak_allowed,
		.o_reserve_bytes, .o_payload_ok, .o_ring_addr, .o_ring_valid,
		.o_dequeue_cycle_bit, .o_ep_state);

	ecsp_sw_model u_sw (.i_ref_clk(i_ref_clk), .i_awready(o_axi_awready),
		.i_wready(o_axi_wready), .i_bvalid(o_axi_bvalid),
		.i_arready(o_axi_arready), .i_rvalid(o_axi_rvalid),
		.o_awaddr(i_axi_awaddr), .o_awvalid(i_axi_awvalid),
		.o_wdata(i_axi_wdata), .o_wvalid(i_axi_wvalid),
		.o_bready(i_axi_bready), .o_araddr(i_axi_araddr),
		.o_arvalid(i_axi_arvalid), .o_rready(i_axi_rready));

	task automatic finish_test;
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] mk = 32'hffff_ffff,
		input logic [1:0] rs = RESP_OKAY);
		rq.push_back('{nm, {rs, e & mk}, {2'b11, mk}});
		u_sw.read_reg(a);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] rs = RESP_OKAY);
		bq.push_back(rs);
		u_sw.write_reg(a, d);
	endtask : wr
	task automatic tick(input int t);
		repeat (t) @(posedge i_ref_clk);
		#1;
	endtask : tick
	// gap in cycles up to the next poll pulse, capped so a dead tick ends
	task automatic tick_gap;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (!o_poll_tick && n < 2000);
	endtask : tick_gap
	function automatic logic [31:0] cfg(input ecsp_speed_type s,
		input ecsp_kind_type kd, input logic d, input logic [1:0] mu,
		input logic [7:0] bu, input logic [7:0] it);
		return 32'(s) | (32'(kd) << KIND_LSB) | (32'(d) << DIR_BIT) |
			(32'(mu) << MULT_LSB) | (32'(bu) << BURST_LSB) | (32'(it) << INTV_LSB);
	endfunction : cfg

	// results are compared in the order the driver noted them
	always @(posedge i_ref_clk) begin
		if (o_axi_rvalid && i_axi_rready) begin
			nt = rq.pop_front();
			chk(nt.nm, nt.v, {o_axi_rresp, o_axi_rdata} & nt.m);
		end
		if (o_axi_bvalid && i_axi_bready)
			chk("bresp", bq.pop_front(), o_axi_bresp);
	end

	initial begin
		#400000;
		mismatches++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		tick(2);
		chk("state rst", EPS_DISABLED, o_ep_state);
		rd("cfg rst", OFF_CFG, 32'h0);
		rd("status rst", OFF_STATUS, 32'h3001, 32'hffff);
		rd("unmapped rd", 8'h40, 32'h0, 32'hffff_ffff, RESP_SLVERR);
		wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
		for (int i = 0; i < 12; i++) begin
			sp = ecsp_speed_type'(3'(($random(seed) & 32'hff) % 5));
			k = ecsp_kind_type'(2'($random(seed)));
			desc = 16'($random(seed));
			b = (i == 1) ? 8'hff : 8'($random(seed));
			if (i == 1) sp = SPD_SS;
			b = u_sw.burst_for(sp, k, desc, b);
			m = (i == 1) ? 2'd3 : 2'($random(seed));
			wr(OFF_CFG, cfg(sp, k, 1'b1, m, b, 8'h0));
			wr(OFF_PKT, {16'($random(seed)), desc});
			tick(2);
			chk("budget", (b + 1) * (m + 1), o_txn_budget);
			chk("pkt per txn", b + 1, o_pkt_per_txn);
			chk("high bw", b != 0, o_high_bw);
			chk("max pkt", desc[10:0], o_max_pkt_bytes);
		end
		wr(OFF_CFG, cfg(SPD_SSP, EPK_ISOC, 1'b1, 2'd0, 8'h0, 8'h0));
		for (int j = 0; j < 6; j++) begin
			@(posedge i_ref_clk);
			i_large_payload_capable <= (j > 2);
			val = (j % 3 == 0) ? SERVICE_INTERVAL_WINDOW_SMALL : (j % 3 == 1) ? 32'hc001 : 32'hffffff;
			wr(OFF_SERVICE_INTERVAL_WINDOW, val);
			tick(2);
			ok = (j > 2) || (val <= SERVICE_INTERVAL_WINDOW_SMALL);
			chk("payload ok", ok, o_payload_ok);
			chk("reserve", ok ? val : 0, o_reserve_bytes);
		end
		rd("caps", OFF_CAPS, 32'h1, 32'h1);
		wr(OFF_CFG, cfg(SPD_SS, EPK_BULK, 1'b1, 2'd0, 8'h0, 8'h1));
		tick(2);
		chk("reserve bulk", 0, o_reserve_bytes);
		tick_gap();
		chk("ss no poll", 2000, n);
		chk("ss no nak", 0, o_nak_allowed);
		for (int j = 0; j < 3; j++) begin
			iv = u_sw.intv_for(psp[j], pk[j], pbi[j]);
			wr(OFF_CFG, cfg(psp[j], pk[j], 1'b1, 2'd0, 8'h0, iv));
			tick_gap();
			tick_gap();
			tick_gap();
			chk("poll period", 8 << iv, n);
		end
		// nak window is interval microframes of 8 cycles each
		wr(OFF_CFG, cfg(SPD_HS, EPK_BULK, 1'b0, 2'd0, 8'h0, 8'h2));
		n = 0;
		while (!o_nak_allowed && n < 40) begin
			tick(1);
			n++;
		end
		chk("nak set", 1, o_nak_allowed);
		@(posedge i_ref_clk);
		i_nak_used <= 1'b1;
		@(posedge i_ref_clk);
		i_nak_used <= 1'b0;
		#1;
		chk("nak used", 0, o_nak_allowed);
		// let the permission come back so a zero rate has something to drop
		n = 0;
		while (!o_nak_allowed && n < 40) begin
			tick(1);
			n++;
		end
		wr(OFF_CFG, cfg(SPD_HS, EPK_CTRL, 1'b0, 2'd0, 8'h0, 8'h0));
		tick(60);
		chk("never nak", 0, o_nak_allowed);
		lo = $random(seed);
		hi = $random(seed);
		wr(OFF_SID, 32'h0);
		wr(OFF_STRM_LO, lo);
		wr(OFF_STRM_HI, hi);
		wr(OFF_STRM_LEN, 32'h0012_3456);
		tick(2);
		chk("ring addr", {hi, lo[31:4], 4'h0}, o_ring_addr);
		chk("ring sid0", 0, o_ring_valid);
		chk("cycle bit", lo[0], o_dequeue_cycle_bit);
		wr(OFF_SID, 32'h5);
		tick(2);
		chk("ring sid5", 1, o_ring_valid);
		wp = {$random(seed), $random(seed)};
		// a write-back offered while the enable is low must be lost
		@(posedge i_ref_clk);
		i_clk_en <= 1'b0;
		i_wb_valid <= 1'b1;
		i_wb_ptr <= '1;
		@(posedge i_ref_clk);
		i_clk_en <= 1'b1;
		i_wb_valid <= 1'b0;
		tick(1);
		chk("frozen addr", {hi, lo[31:4], 4'h0}, o_ring_addr);
		@(posedge i_ref_clk);
		i_wb_valid <= 1'b1;
		i_wb_ptr <= wp[63:4];
		i_wb_cycle <= ~lo[0];
		i_wb_len <= 24'habcdef;
		@(posedge i_ref_clk);
		i_wb_valid <= 1'b0;
		tick(1);
		chk("wb addr", {wp[63:4], 4'h0}, o_ring_addr);
		rd("wb lo", OFF_STRM_LO, {wp[31:4], 3'h0, ~lo[0]},
			32'hffff_fff1);
		rd("wb hi", OFF_STRM_HI, wp[63:32]);
		rd("wb len", OFF_STRM_LEN, 32'habcdef, 32'hffffff);
		c = cfg(SPD_HS, EPK_CTRL, 1'b1, 2'd3, 8'h5, 8'h7) | (32'h2 << ERROR_RETRY_COUNT_LSB);
		wr(OFF_CFG, c | (32'(EPS_STOPPED) << STATE_LSB));
		wr(OFF_PKT, 32'h0040_0040);
		// only the two low byte lanes may land
		@(posedge i_ref_clk);
		i_axi_wstrb <= 4'h3;
		wr(OFF_PKT, 32'hffff_0041);
		i_axi_wstrb <= 4'hf;
		wr(OFF_SERVICE_INTERVAL_WINDOW, 32'h100);
		wr(OFF_CMD, 32'h1);
		tick(2);
		rd("cfg dev rst", OFF_CFG,
			(c & 32'h0300_003f) | (32'h1 << STATE_LSB));
		rd("pkt dev rst", OFF_PKT, 32'h0040_0041);
		rd("service_interval_window dev rst", OFF_SERVICE_INTERVAL_WINDOW, 32'h0);
		rd("cmd rd", OFF_CMD, 32'h0);
		chk("state dev rst", EPS_RUNNING, o_ep_state);
		chk("budget dev rst", 1, o_txn_budget);
		chk("ring dev rst", {wp[63:4], 4'h0}, o_ring_addr);
		tick(4);
		finish_test();
	end
endmodule : test_endpoint_context_scheduling_params
